/* rtl/sac_params.svh */
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// converter register offsets, one 32-bit word each
`define SAC_OFF_CFG 8'h00
`define SAC_OFF_CTRL 8'h04
`define SAC_OFF_STAT 8'h08
`define SAC_OFF_ISR 8'h0c
`define SAC_OFF_IMR 8'h10
`define SAC_OFF_RES 8'h20
`define SAC_OFF_CMP 8'h40
`define SAC_BANK_MASK 8'he0

// field positions
`define SAC_CFG_CONT 0
`define SAC_CFG_RES 1
`define SAC_CFG_CHM 8
`define SAC_CFG_TRG 16
`define SAC_CTRL_START 0
`define SAC_CTRL_STOP 1
`define SAC_CTRL_UPD 2
`define SAC_STAT_BUSY 0
`define SAC_STAT_PEND 1
`define SAC_INT_DONE 0
`define SAC_INT_CMP 1
`define SAC_RES_GE 16
`define SAC_CMP_EN 16

// reset values
`define SAC_RST_RES 4'ha
`define SAC_RST_CHM 8'hff
`define SAC_RST_HALF 8'h1c

// controller-side registers
`define SAC_HOST_BASE 10'h200
`define SAC_HOFF_CLK 10'h200
`define SAC_HOFF_TMR 10'h204
`define SAC_HOFF_STAMP 10'h208
`define SAC_HCLK_EN 0
`define SAC_HCLK_HALF 8

// timing: system clock and converter clock ceiling, in kHz
`define SAC_SYS_KHZ 250000
`define SAC_CONV_MAX_KHZ 4500
`define SAC_MIN_HALF ((`SAC_SYS_KHZ + 2 * `SAC_CONV_MAX_KHZ - 1) / (2 * `SAC_CONV_MAX_KHZ))

`endif

/* rtl/sac_pkg.sv */
`default_nettype none

package sac_pkg;

    // conversion sequencer states
    typedef enum {CV_IDLE, CV_SAMPLE, CV_BITS} sac_cstate_t;

    // configuration word carried into the conversion domain
    typedef struct packed {
        logic cont;
        logic [3:0] res;
        logic [7:0] chm;
        logic [3:0] trg;
    } sac_cfg_t;

endpackage

`default_nettype wire

/* rtl/sac_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface sac_if;
    logic conv_clk;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] start;
    logic irq;

    modport dev (
        input conv_clk, wr, rd, addr, wdata, start,
        output rdata, irq
    );
    modport host (
        output conv_clk, wr, rd, addr, wdata, start,
        input rdata, irq
    );
endinterface

`default_nettype wire

/* rtl/sac_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sac_params.svh"

module sac_host
    import sac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [9:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic ext_start_pin,
    input wire logic pwm_sync,
    input wire logic prev_done,
    output logic pwm_start,
    sac_if.host lnk
);
    logic en_q, en_d, cclk_q, cclk_d, pwm_q, pwm_d, irq_q, irq_d;
    logic [7:0] half_q, half_d, cnt_q, cnt_d;
    logic [15:0] tper_q, tper_d, tcnt_q, tcnt_d, free_q, free_d, stamp_q, stamp_d;
    logic pin_s1_q, pin_s2_q, pin_s3_q, sync_p_q, prev_p_q;
    logic [3:0] start_q, start_d;
    logic [31:0] rdata_q, rdata_d;
    logic hreg, fire;
    logic [3:0] ev;

    // device reached only with its clock on
    assign hreg = addr >= `SAC_HOST_BASE;
    assign lnk.wr = wr & ~hreg & en_q;
    assign lnk.rd = rd & ~hreg & en_q;
    assign lnk.addr = addr[7:0];
    assign lnk.wdata = wdata;
    assign lnk.start = start_q;
    assign lnk.conv_clk = cclk_q;
    assign rdata = rdata_q;
    assign irq = irq_q;
    assign pwm_start = pwm_q;

    // next state of divider, timer, triggers and register port
    always_comb begin
        en_d = en_q;
        half_d = half_q;
        tper_d = tper_q;
        rdata_d = rdata_q;
        cnt_d = cnt_q + 8'h01;
        cclk_d = cclk_q;
        if (!en_q) begin
            cnt_d = 8'h00;
            cclk_d = 1'b0;
        end else if (cnt_q >= half_q - 8'h01) begin
            cnt_d = 8'h00;
            cclk_d = ~cclk_q;
        end
        // timer 0 starts converter and pwm
        fire = (tper_q != 16'h0000) && (tcnt_q == tper_q);
        // held at zero while off, so a new period counts from a clean start
        tcnt_d = (fire || tper_q == 16'h0000) ? 16'h0000 : tcnt_q + 16'h0001;
        pwm_d = fire;
        free_d = free_q + 16'h0001;
        // each event toggles its start line so slow sampling never loses it
        ev = {prev_done & ~prev_p_q, pwm_sync & ~sync_p_q, fire, pin_s2_q & ~pin_s3_q};
        start_d = start_q ^ ev;
        stamp_d = (|ev) ? free_q : stamp_q;
        if (wr && hreg) begin
            unique case (addr)
                `SAC_HOFF_CLK: begin
                    en_d = wdata[`SAC_HCLK_EN];
                    half_d = wdata[`SAC_HCLK_HALF +: 8];
                    if (half_d < 8'(`SAC_MIN_HALF)) begin
                        half_d = 8'(`SAC_MIN_HALF);
                    end
                end
                `SAC_HOFF_TMR: tper_d = wdata[15:0];
                default: ;
            endcase
        end
        if (rd) begin
            if (!hreg) begin
                rdata_d = en_q ? lnk.rdata : 32'h0000_0000;
            end else if (addr == `SAC_HOFF_CLK) begin
                rdata_d = 32'(en_q) | (32'(half_q) << `SAC_HCLK_HALF);
            end else if (addr == `SAC_HOFF_TMR) begin
                rdata_d = 32'(tper_q);
            end else if (addr == `SAC_HOFF_STAMP) begin
                rdata_d = 32'(stamp_q);
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
        irq_d = lnk.irq;
    end

    // registers; the pin passes two flops before the edge detector
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_q <= 1'b0;
            half_q <= `SAC_RST_HALF;
            cnt_q <= 8'h00;
            cclk_q <= 1'b0;
            tper_q <= 16'h0000;
            tcnt_q <= 16'h0000;
            free_q <= 16'h0000;
            stamp_q <= 16'h0000;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            sync_p_q <= 1'b0;
            prev_p_q <= 1'b0;
            start_q <= 4'h0;
            pwm_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            en_q <= en_d;
            half_q <= half_d;
            cnt_q <= cnt_d;
            cclk_q <= cclk_d;
            tper_q <= tper_d;
            tcnt_q <= tcnt_d;
            free_q <= free_d;
            stamp_q <= stamp_d;
            pin_s1_q <= ext_start_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            sync_p_q <= pwm_sync;
            prev_p_q <= prev_done;
            start_q <= start_d;
            pwm_q <= pwm_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end
endmodule

`default_nettype wire

/* rtl/sac_dev.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sac_params.svh"

// What this block does
// - conversion takes resolution plus one clocks
// - software picks resolution two to ten bits
// - single scan or continuous scan
// - scan starts on transition of enabled source
// - one result register per channel
// - per-channel compare gives less or greater-equal
// - starts 0,2 system side; 1,3 converter side
// - configuration copied over on software command
// - bus accesses only while converter clock runs
// - eight inputs multiplexed, one at a time
// - converter clock at most 4.5 MHz
// - sequencing on converter clock, registers on system
// - timer 0 feeds converter and first pwm
// - timer captures record converter start moment
module sac_dev
    import sac_pkg::*;
#(
    parameter int NCH = 8,
    parameter int RES_W = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sac_if.dev lnk,
    input wire logic cmp_in,
    output logic [$clog2(NCH)-1:0] chan_sel,
    output logic [RES_W-1:0] dac_code,
    output logic sample
);
    localparam int CW = $clog2(NCH);

    if (NCH < 2 || NCH > 8 || RES_W < 2 || RES_W > 15) begin : g_chk
        $error("sac_dev: NCH must be 2..8 and RES_W 2..15");
    end

    // system side state
    sac_cfg_t cfg_q, cfg_d, xfer_q, xfer_d;
    logic pend_q, pend_d, irq_q, irq_d;
    logic [1:0] isr_q, isr_d, imr_q, imr_d;
    logic [4:0] tgl_q, tgl_d;
    logic [1:0] stp_q;
    logic [1:0] b_s1_q, b_s2_q, b_s3_q, be;
    logic busy_s1_q, busy_s2_q;
    logic [RES_W-1:0] res_q [NCH];
    logic [RES_W-1:0] res_d [NCH];
    logic [RES_W-1:0] cmpv_q [NCH];
    logic [RES_W-1:0] cmpv_d [NCH];
    logic [NCH-1:0] ge_q, ge_d, cen_q, cen_d;
    logic [CW-1:0] widx;
    logic wres, wcmp, nge;

    // converter side state
    sac_cstate_t st_q, st_d;
    sac_cfg_t act_q, act_d;
    logic [6:0] c_s1_q, c_s2_q, c_s3_q, ce;
    logic [CW-1:0] ch_q, ch_d, rch_q, rch_d;
    logic [RES_W-1:0] dac_q, dac_d, rval_q, rval_d, keep;
    logic [3:0] idx_q, idx_d, lo_q, lo_d, r;
    logic samp_q, samp_d, busy_q, ack_q, ack_d, rtgl_q, rtgl_d, rlast_q, rlast_d, go;
    logic [CW:0] nx;

    // lowest enabled channel at or above from, with a found bit on top
    function automatic logic [CW:0] pick(input logic [7:0] m, input int from);
        logic [CW:0] p;
        p = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i] && i >= from) begin
                p = {1'b1, CW'(i)};
            end
        end
        return p;
    endfunction

    assign widx = lnk.addr[2 +: CW];
    assign wres = (lnk.addr & `SAC_BANK_MASK) == `SAC_OFF_RES && int'(lnk.addr[4:2]) < NCH;
    assign wcmp = (lnk.addr & `SAC_BANK_MASK) == `SAC_OFF_CMP && int'(lnk.addr[4:2]) < NCH;
    assign be = b_s2_q ^ b_s3_q;
    assign lnk.irq = irq_q;
    assign chan_sel = ch_q;
    assign dac_code = dac_q;
    assign sample = samp_q;

    // register handling on the system clock
    always_comb begin
        cfg_d = cfg_q;
        xfer_d = xfer_q;
        pend_d = pend_q;
        imr_d = imr_q;
        isr_d = isr_q;
        tgl_d = tgl_q;
        res_d = res_q;
        cmpv_d = cmpv_q;
        ge_d = ge_q;
        cen_d = cen_q;
        nge = 1'b0;
        if (lnk.wr) begin
            if (lnk.addr == `SAC_OFF_CFG) begin
                cfg_d.cont = lnk.wdata[`SAC_CFG_CONT];
                cfg_d.res = lnk.wdata[`SAC_CFG_RES +: 4];
                cfg_d.chm = lnk.wdata[`SAC_CFG_CHM +: 8];
                cfg_d.trg = lnk.wdata[`SAC_CFG_TRG +: 4];
            end else if (lnk.addr == `SAC_OFF_CTRL) begin
                tgl_d[0] = tgl_q[0] ^ lnk.wdata[`SAC_CTRL_START];
                tgl_d[1] = tgl_q[1] ^ lnk.wdata[`SAC_CTRL_STOP];
                if (lnk.wdata[`SAC_CTRL_UPD] && !pend_q) begin
                    xfer_d = cfg_q;
                    pend_d = 1'b1;
                    tgl_d[2] = ~tgl_q[2];
                end
            end else if (lnk.addr == `SAC_OFF_ISR) begin
                isr_d = isr_q & ~lnk.wdata[1:0];
            end else if (lnk.addr == `SAC_OFF_IMR) begin
                imr_d = lnk.wdata[1:0];
            end else if (wcmp) begin
                cmpv_d[widx] = lnk.wdata[RES_W-1:0];
                cen_d[widx] = lnk.wdata[`SAC_CMP_EN];
            end
        end
        // starts 0 and 2 taken on system clock
        tgl_d[3] = tgl_q[3] ^ lnk.start[0] ^ stp_q[0];
        tgl_d[4] = tgl_q[4] ^ lnk.start[2] ^ stp_q[1];
        if (be[1]) begin
            pend_d = 1'b0;
        end
        // result lands in its channel slot
        if (be[0]) begin
            res_d[rch_q] = rval_q;
            nge = rval_q >= cmpv_q[rch_q];
            if (cen_q[rch_q]) begin
                ge_d[rch_q] = nge;
                // a flip of the compare flag is the event, set beats clear
                if (nge != ge_q[rch_q]) begin
                    isr_d[`SAC_INT_CMP] = 1'b1;
                end
            end
            if (rlast_q) begin
                isr_d[`SAC_INT_DONE] = 1'b1;
            end
        end
        irq_d = |(isr_d & imr_d);
    end

    // read mux, answered the same cycle; the controller registers it
    always_comb begin
        lnk.rdata = 32'h0000_0000;
        if (lnk.addr == `SAC_OFF_CFG) begin
            lnk.rdata = (32'(cfg_q.cont) << `SAC_CFG_CONT) | (32'(cfg_q.res) << `SAC_CFG_RES)
                | (32'(cfg_q.chm) << `SAC_CFG_CHM) | (32'(cfg_q.trg) << `SAC_CFG_TRG);
        end else if (lnk.addr == `SAC_OFF_STAT) begin
            lnk.rdata = (32'(busy_s2_q) << `SAC_STAT_BUSY) | (32'(pend_q) << `SAC_STAT_PEND);
        end else if (lnk.addr == `SAC_OFF_ISR) begin
            lnk.rdata = 32'(isr_q);
        end else if (lnk.addr == `SAC_OFF_IMR) begin
            lnk.rdata = 32'(imr_q);
        end else if (wres) begin
            lnk.rdata = 32'(res_q[widx]) | (32'(ge_q[widx]) << `SAC_RES_GE);
        end else if (wcmp) begin
            lnk.rdata = 32'(cmpv_q[widx]) | (32'(cen_q[widx]) << `SAC_CMP_EN);
        end
    end

    // system registers; b_s1 and busy_s1 feed only the second stage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '{cont: 1'b0, res: `SAC_RST_RES, chm: `SAC_RST_CHM, trg: 4'h0};
            xfer_q <= '{cont: 1'b0, res: `SAC_RST_RES, chm: `SAC_RST_CHM, trg: 4'h0};
            pend_q <= 1'b0;
            isr_q <= 2'h0;
            imr_q <= 2'h0;
            irq_q <= 1'b0;
            tgl_q <= 5'h00;
            stp_q <= 2'h0;
            b_s1_q <= 2'h0;
            b_s2_q <= 2'h0;
            b_s3_q <= 2'h0;
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
            res_q <= '{default: '0};
            cmpv_q <= '{default: '0};
            ge_q <= '0;
            cen_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            xfer_q <= xfer_d;
            pend_q <= pend_d;
            isr_q <= isr_d;
            imr_q <= imr_d;
            irq_q <= irq_d;
            tgl_q <= tgl_d;
            stp_q <= {lnk.start[2], lnk.start[0]};
            b_s1_q <= {ack_q, rtgl_q};
            b_s2_q <= b_s1_q;
            b_s3_q <= b_s2_q;
            busy_s1_q <= busy_q;
            busy_s2_q <= busy_s1_q;
            res_q <= res_d;
            cmpv_q <= cmpv_d;
            ge_q <= ge_d;
            cen_q <= cen_d;
        end
    end

    // toggles and starts 1,3 seen once after two flops
    assign ce = c_s2_q ^ c_s3_q;

    always_comb begin
        st_d = st_q;
        act_d = act_q;
        ch_d = ch_q;
        dac_d = dac_q;
        idx_d = idx_q;
        lo_d = lo_q;
        ack_d = ack_q;
        rtgl_d = rtgl_q;
        rval_d = rval_q;
        rch_d = rch_q;
        rlast_d = rlast_q;
        keep = dac_q;
        nx = '0;
        r = act_q.res;
        // enabled source transitions start a scan
        go = ce[0] | (act_q.trg[0] & ce[3]) | (act_q.trg[1] & ce[5])
            | (act_q.trg[2] & ce[4]) | (act_q.trg[3] & ce[6]);
        // take the staged configuration and acknowledge
        if (ce[2]) begin
            act_d = xfer_q;
            ack_d = ~ack_q;
        end
        unique case (st_q)
            CV_IDLE: begin
                nx = pick(act_q.chm, 0);
                if (go && nx[CW]) begin
                    ch_d = nx[CW-1:0];
                    st_d = CV_SAMPLE;
                end
            end
            CV_SAMPLE: begin
                // resolution clamped to the supported span
                if (r < 4'h2) begin
                    r = 4'h2;
                end else if (r > 4'(RES_W)) begin
                    r = 4'(RES_W);
                end
                lo_d = 4'(RES_W) - r;
                idx_d = 4'(RES_W - 1);
                dac_d = RES_W'(1) << (RES_W - 1);
                st_d = CV_BITS;
            end
            CV_BITS: begin
                // comparator high keeps the trial bit
                keep = cmp_in ? dac_q : dac_q & ~(RES_W'(1) << idx_q);
                // one sample clock plus one per bit
                if (idx_q == lo_q) begin
                    rval_d = keep >> lo_q;
                    rch_d = ch_q;
                    rtgl_d = ~rtgl_q;
                    nx = pick(act_q.chm, int'(ch_q) + 1);
                    rlast_d = ~nx[CW];
                    if (!nx[CW] && act_q.cont) begin
                        nx = pick(act_q.chm, 0);
                    end
                    if (nx[CW]) begin
                        ch_d = nx[CW-1:0];
                        st_d = CV_SAMPLE;
                    end else begin
                        st_d = CV_IDLE;
                    end
                end else begin
                    idx_d = idx_q - 4'h1;
                    dac_d = keep | (RES_W'(1) << (idx_q - 4'h1));
                end
            end
        endcase
        // stop ends the scan at once
        if (ce[1]) begin
            st_d = CV_IDLE;
            // an aborted trial code must not look like a live conversion
            dac_d = '0;
        end
        samp_d = st_d == CV_SAMPLE;
    end

    // converter registers; c_s1 feeds only c_s2
    always_ff @(posedge lnk.conv_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= CV_IDLE;
            act_q <= '{cont: 1'b0, res: `SAC_RST_RES, chm: `SAC_RST_CHM, trg: 4'h0};
            c_s1_q <= 7'h00;
            c_s2_q <= 7'h00;
            c_s3_q <= 7'h00;
            ch_q <= '0;
            dac_q <= '0;
            idx_q <= 4'h0;
            lo_q <= 4'h0;
            samp_q <= 1'b0;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            rtgl_q <= 1'b0;
            rval_q <= '0;
            rch_q <= '0;
            rlast_q <= 1'b0;
        end else begin
            st_q <= st_d;
            act_q <= act_d;
            // starts 1 and 3 taken on converter clock
            c_s1_q <= {lnk.start[3], lnk.start[1], tgl_q};
            c_s2_q <= c_s1_q;
            c_s3_q <= c_s2_q;
            ch_q <= ch_d;
            dac_q <= dac_d;
            idx_q <= idx_d;
            lo_q <= lo_d;
            samp_q <= samp_d;
            busy_q <= st_d != CV_IDLE;
            ack_q <= ack_d;
            rtgl_q <= rtgl_d;
            rval_q <= rval_d;
            rch_q <= rch_d;
            rlast_q <= rlast_d;
        end
    end
endmodule

`default_nettype wire

/* bench/sac_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module sac_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic conv_clk,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] start,
    input wire logic pwm_start,
    input wire logic irq,
    input wire logic sample,
    input wire logic [2:0] chan_sel,
    input wire logic [9:0] dac_code
);
    logic ck_q, s1_q, s1_d, s2_q, s2_d, fall, chg;
    logic [2:0] ch_q, ch_d;
    logic [7:0] half_q, half_d, gap_q, gap_d;
    // conv clock edges as seen from the system side
    assign fall = ck_q & ~conv_clk;
    assign chg = ck_q ^ conv_clk;
    // history per conv period, taken mid-period so it never races the edge
    always_comb begin
        half_d = chg ? 8'h00 : (half_q == 8'hff ? half_q : half_q + 8'h01);
        s1_d = s1_q;
        s2_d = s2_q;
        ch_d = ch_q;
        gap_d = gap_q;
        if (fall) begin
            s1_d = sample;
            s2_d = s1_q;
            ch_d = chan_sel;
            gap_d = sample ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ck_q <= 1'b0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            ch_q <= 3'h0;
            half_q <= 8'hff;
            gap_q <= 8'hff;
        end else begin
            ck_q <= conv_clk;
            s1_q <= s1_d;
            s2_q <= s2_d;
            ch_q <= ch_d;
            half_q <= half_d;
            gap_q <= gap_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_HALF_MIN: assert property (chg |-> half_q >= 8'd27)
        else $error("converter clock half period too short");
    AST_BUS_CLOCKED: assert property ((wr || rd) |-> half_q < 8'd100)
        else $error("converter access with its clock stopped");
    AST_ONE_SAMPLE: assert property (fall && s1_q |-> !sample)
        else $error("sample longer than one conv period");
    AST_GAP_MIN: assert property (fall && sample |-> gap_q >= 8'd2)
        else $error("fewer than two bit periods in a conversion");
    AST_CHAN_HOLD: assert property (fall && s1_q && dac_code != '0 |-> chan_sel == ch_q)
        else $error("channel changed inside a conversion");
    AST_FIRST_TRIAL: assert property (fall && s1_q && dac_code != '0 |-> dac_code == 10'h200)
        else $error("first trial code wrong");
    AST_SECOND_TRIAL: assert property (
        fall && s2_q && dac_code != '0 |-> dac_code[8] && dac_code[7:0] == 8'h00)
        else $error("second trial code wrong");
    AST_TIMER_START: assert property (pwm_start |-> ##[0:2] $changed(start[1]))
        else $error("timer fire without start toggle");
    cover property (fall && sample);
    cover property (pwm_start);
    cover property ($rose(irq));
endmodule

`default_nettype wire

/* bench/sac_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module sac_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0, rd = 1'b0, ext_trig = 1'b0, pwm_sync = 1'b0, prev_done = 1'b0;
    logic cmp_in = 1'b0;
    logic [31:0] rdata, rv;
    logic irq, pwm_start, sample;
    logic [2:0] chan_sel;
    logic [9:0] dac_code;
    logic [9:0] ain [8] = '{10'h155, 10'h3ff, 10'h2c5, 10'h0, 10'h1, 10'h200, 10'h1ff, 10'h0aa};
    int fail_count = 0, total_checks = 0, cyc = 0;
    sac_if lnk();
    sac_host i_sac_host (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ext_start_pin(ext_trig),
        .pwm_sync(pwm_sync), .prev_done(prev_done), .pwm_start(pwm_start), .lnk(lnk));
    sac_dev i_sac_dev (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk), .cmp_in(cmp_in),
        .chan_sel(chan_sel), .dac_code(dac_code), .sample(sample));
    sac_checker i_sac_checker (.clk_sys(clk_sys), .rstn(rstn), .conv_clk(lnk.conv_clk),
        .wr(lnk.wr), .rd(lnk.rd), .start(lnk.start), .pwm_start(pwm_start), .irq(lnk.irq),
        .sample(sample), .chan_sel(chan_sel), .dac_code(dac_code));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // analogue comparator stand-in
    always @(posedge clk_sys) cmp_in <= (ain[chan_sel] >= dac_code);
    // hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_reg(input logic [9:0] a, input logic [31:0] e, input string nm);
        rreg(a, rv);
        check(nm, rv, e);
    endtask
    function automatic logic [31:0] cw(input logic c, input logic [3:0] r,
        input logic [7:0] m, input logic [3:0] t);
        return {12'h000, t, m, 3'h0, r, c};
    endfunction
    task automatic wait_done();
        int n = 0;
        do begin
            rreg(10'h00c, rv);
            n++;
        end while (rv[0] !== 1'b1 && n < 4000);
        check("scan done", rv[0], 1'b1);
    endtask
    task automatic setcfg(input logic [31:0] c);
        int n = 0;
        wreg(10'h000, c);
        wreg(10'h004, 32'h4);
        do begin
            rreg(10'h008, rv);
            n++;
        end while (rv[1] !== 1'b0 && n < 200);
        check("transfer pending", rv[1], 1'b0);
    endtask
    task automatic run();
        wreg(10'h00c, 32'h3);
        wreg(10'h004, 32'h1);
        wait_done();
    endtask
    task automatic fire(input int i);
        @(posedge clk_sys);
        case (i)
            0: ext_trig <= 1'b1;
            2: pwm_sync <= 1'b1;
            default: prev_done <= 1'b1;
        endcase
        repeat (8) @(posedge clk_sys);
        {ext_trig, pwm_sync, prev_done} <= 3'b000;
    endtask
    task automatic t_regs();
        chk_reg(10'h000, 32'h0, "cfg clock off");
        wreg(10'h200, 32'h0000_0501);
        repeat (40) @(posedge clk_sys);
        chk_reg(10'h200, 32'h0000_1c01, "clk half floor");
        chk_reg(10'h000, 32'h0000_ff14, "cfg reset");
        chk_reg(10'h3fc, 32'h0, "unmapped");
    endtask
    task automatic t_scan();
        setcfg(cw(0, 4'ha, 8'h81, 4'h0));
        wreg(10'h010, 32'h0);
        run();
        check("irq masked", irq, 1'b0);
        wreg(10'h010, 32'h1);
        repeat (4) @(posedge clk_sys);
        check("irq set", irq, 1'b1);
        wreg(10'h00c, 32'h1);
        repeat (4) @(posedge clk_sys);
        check("irq clear", irq, 1'b0);
        chk_reg(10'h008, 32'h0, "single stops");
        for (int c = 0; c < 8; c++) begin
            rreg(10'h020 + 10'(4 * c), rv);
            check("result", rv[9:0], (c == 0 || c == 7) ? ain[c] : 10'h0);
        end
    endtask
    task automatic t_res();
        int rl[3] = '{2, 5, 10};
        foreach (rl[i]) begin
            setcfg(cw(0, 4'(rl[i]), 8'h04, 4'h0));
            run();
            rreg(10'h028, rv);
            check("result width", rv[9:0], ain[2] >> (10 - rl[i]));
        end
        wreg(10'h000, cw(0, 4'h2, 8'h04, 4'h0));
        run();
        rreg(10'h028, rv);
        check("old config kept", rv[9:0], ain[2]);
    endtask
    task automatic t_cmp();
        setcfg(cw(0, 4'ha, 8'h04, 4'h0));
        for (int k = 0; k < 2; k++) begin
            wreg(10'h048, 32'h1_0000 | (k ? ain[2] + 10'h1 : ain[2]));
            run();
            rreg(10'h028, rv);
            check("ge flag", rv[16], !k);
            rreg(10'h00c, rv);
            check("cmp change", rv[1], 1'b1);
        end
    endtask
    task automatic t_cont();
        int n = 0;
        logic ls = 1'b0;
        setcfg(cw(1, 4'h3, 8'h01, 4'h0));
        wreg(10'h004, 32'h1);
        repeat (1200) begin
            @(posedge clk_sys);
            #1 if (sample === 1'b1 && !ls) n++;
            ls = sample;
        end
        check("rescans", n > 2, 1'b1);
        chk_reg(10'h008, 32'h1, "busy cont");
        wreg(10'h004, 32'h2);
        repeat (400) @(posedge clk_sys);
        chk_reg(10'h008, 32'h0, "stopped");
    endtask
    task automatic t_trig();
        int n = 0;
        logic [15:0] s0;
        setcfg(cw(0, 4'h2, 8'h01, 4'hf));
        for (int i = 0; i < 4; i++) begin
            wreg(10'h00c, 32'h3);
            if (i == 1) wreg(10'h204, 32'h0fa0);
            else fire(i);
            wait_done();
            wreg(10'h204, 32'h0);
        end
        setcfg(cw(0, 4'h2, 8'h01, 4'h0));
        wreg(10'h00c, 32'h3);
        fire(0);
        repeat (600) @(posedge clk_sys);
        chk_reg(10'h00c, 32'h0, "disabled start");
        wreg(10'h204, 32'd99);
        repeat (200) @(posedge clk_sys);
        repeat (1000) begin
            @(posedge clk_sys);
            #1 if (pwm_start === 1'b1) n++;
        end
        check("timer pulses", n, 10);
        // stamps read a period apart step by the timer period plus one
        rreg(10'h208, rv);
        s0 = rv[15:0];
        repeat (98) @(posedge clk_sys);
        rreg(10'h208, rv);
        check("stamp step", 16'(rv[15:0] - s0), 16'd100);
        wreg(10'h204, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_scan();
        t_res();
        t_cmp();
        t_cont();
        t_trig();
        results();
    end
endmodule

`default_nettype wire
